// >>> hdl/codec_regs_defs.svh
// Purpose: Constants of the ADC input gain and mix register bank.
// Assumes: Registers are eight bits wide, addressed by a seven-bit page-0 number.
// Notes: Shared by the device end and the host end.
// How it works
// [RULE1] Register 13 resets zero; host writes zero
// [RULE2] Register 14 bit 7 selects driver coupling
// [RULE3] Register 14 bit 6 flags fully differential
// [RULE4] Register 14 bit 3 flags pseudodifferential
// [RULE5] Host never sets bits 6 and 3 together
// [RULE6] Register 14 bit 4 is read-only headset flag
// [RULE7] Register 14 bits 5,2..0 reserved read zero
// [RULE8] Register 15 bit 7 mutes left amplifier
// [RULE9] Register 16 bit 7 mutes right amplifier
// [RULE10] Left gain half-dB steps, saturating at 0x77
// [RULE11] Right gain same encoding, saturating too
// [RULE12] Second-left level codes 0..8; 9..14 forbidden
// [RULE13] Second-left code 15 disconnects; reset value
// [RULE14] Any level code 0..8 connects the input
// [RULE15] Second-right level same encoding; 9..14 forbidden
// [RULE16] Second-right code 15 disconnects; reset value
// [RULE17] Reads return held values; read-only bits kept
`ifndef CODEC_REGS_DEFS_SVH
`define CODEC_REGS_DEFS_SVH

`define ADDR_RESERVED_ZERO 7'h0d
`define ADDR_HEADSET_DRIVER 7'h0e
`define ADDR_LEFT_GAIN 7'h0f
`define ADDR_RIGHT_GAIN 7'h10
`define ADDR_SECOND_MIX 7'h11

`define BIT_COUPLING 7
`define BIT_FULL_DIFF 6
`define BIT_HEADSET 4
`define BIT_PSEUDO_DIFF 3
`define BIT_MUTE 7
`define HDC_WRITABLE_MASK 8'hc8

`define RST_RESERVED_ZERO 8'h00
`define RST_HEADSET_DRIVER 3'h0
`define RST_MUTE 1'b1
`define RST_GAIN 7'h00
`define RST_LEVEL 4'hf

`define GAIN_MAX 7'h77
`define LEVEL_MAX 4'h8
`define LEVEL_OFF 4'hf

`define GAIN_BITS 6:0
`define LEVEL_HI 7:4
`define LEVEL_LO 3:0
`define RSVD_BIT 1'b0
`define RSVD_LOW_BITS 3'h0

`endif

// >>> hdl/codec_regs_pkg.sv
// Purpose: Types shared by both ends of the register link.
// Assumes: Constants come from codec_regs_defs.svh.
// Notes: None.
`default_nettype none
package codec_regs_pkg;
  typedef logic [6:0] reg_addr_type;
  typedef logic [7:0] reg_data_type;
  typedef logic [6:0] gain_code_type;
  typedef logic [3:0] level_code_type;
  typedef enum logic [0:0] {
    host_idle = 1'b0,
    host_busy = 1'b1
  } host_state_type;
endpackage
`default_nettype wire

// >>> hdl/codec_regs_if.sv
// Purpose: Register link between host controller and codec register bank.
// Assumes: Both ends run on one clock.
// Notes: req holds until ack; ack is a one-cycle pulse with rdata.
`default_nettype none
interface codec_regs_if
  import codec_regs_pkg::*;
(
  input wire logic clk
);
  logic req;
  logic we;
  reg_addr_type addr;
  reg_data_type wdata;
  logic ack;
  reg_data_type rdata;

  modport device (input clk, input req, input we, input addr, input wdata,
    output ack, output rdata);
  modport host (input clk, output req, output we, output addr, output wdata,
    input ack, input rdata);
endinterface
`default_nettype wire

// >>> hdl/codec_regs_device.sv
// Purpose: Register bank for ADC amplifier gain, mute, driver config and left and right mix.
// Assumes: Host keeps req high until ack; headset pin is asynchronous.
// Notes: Unmapped addresses read zero and ignore writes.
`include "codec_regs_defs.svh"
`default_nettype none
module codec_regs_device
  import codec_regs_pkg::*;
(
  input wire logic rst_n,
  codec_regs_if.device bus,
  input wire logic headset_pin,
  output logic driver_ac_coupled,
  output logic full_diff_out,
  output logic pseudo_diff_out,
  output logic left_amp_mute,
  output logic right_amp_mute,
  output logic [6:0] left_amp_gain,
  output logic [6:0] right_amp_gain,
  output logic [3:0] second_left_input_level,
  output logic second_left_input_connected,
  output logic [3:0] second_right_input_level,
  output logic second_right_input_connected
);
  logic headset_meta;
  logic headset_sync;
  reg_data_type reserved_zero_reg;
  logic coupling;
  logic full_diff;
  logic pseudo_diff;
  logic left_mute;
  logic right_mute;
  gain_code_type left_gain;
  gain_code_type right_gain;
  level_code_type left_level;
  level_code_type right_level;
  logic take;
  logic wr;
  logic hit_reserved;
  logic hit_config;
  logic hit_left;
  logic hit_right;
  logic hit_mix;

  // Saturate the gain code at the 59.5 dB step
  function automatic gain_code_type sat_gain(input gain_code_type code);
    sat_gain = (code > `GAIN_MAX) ? `GAIN_MAX : code;
  endfunction

  // Only codes 0..8 carry a gain and connect
  function automatic logic level_connects(input level_code_type code);
    level_connects = (code <= `LEVEL_MAX);
  endfunction

  assign take = bus.req && !bus.ack;
  assign wr = take && bus.we;

  // One-hot register select from the page-0 number
  always_comb
  begin
    hit_reserved = 1'b0;
    hit_config = 1'b0;
    hit_left = 1'b0;
    hit_right = 1'b0;
    hit_mix = 1'b0;
    if (bus.addr == `ADDR_RESERVED_ZERO)
      hit_reserved = 1'b1;
    else if (bus.addr == `ADDR_HEADSET_DRIVER)
      hit_config = 1'b1;
    else if (bus.addr == `ADDR_LEFT_GAIN)
      hit_left = 1'b1;
    else if (bus.addr == `ADDR_RIGHT_GAIN)
      hit_right = 1'b1;
    else if (bus.addr == `ADDR_SECOND_MIX)
      hit_mix = 1'b1;
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      headset_meta <= 1'b0;
      headset_sync <= 1'b0;
    end
    else
    begin
      headset_meta <= headset_pin;
      headset_sync <= headset_meta; // RULE6
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
      bus.ack <= 1'b0;
    else
      bus.ack <= take;
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
      reserved_zero_reg <= `RST_RESERVED_ZERO; // RULE1
    else if (wr && hit_reserved)
      reserved_zero_reg <= bus.wdata;
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      {coupling, full_diff, pseudo_diff} <= `RST_HEADSET_DRIVER;
    end
    else if (wr && hit_config)
    begin
      coupling <= bus.wdata[`BIT_COUPLING]; // RULE2
      full_diff <= bus.wdata[`BIT_FULL_DIFF]; // RULE3
      pseudo_diff <= bus.wdata[`BIT_PSEUDO_DIFF]; // RULE4
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      left_mute <= `RST_MUTE; // RULE8
      left_gain <= `RST_GAIN; // RULE10
    end
    else if (wr && hit_left)
    begin
      left_mute <= bus.wdata[`BIT_MUTE]; // RULE8
      left_gain <= bus.wdata[`GAIN_BITS]; // RULE10
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      right_mute <= `RST_MUTE; // RULE9
      right_gain <= `RST_GAIN; // RULE11
    end
    else if (wr && hit_right)
    begin
      right_mute <= bus.wdata[`BIT_MUTE]; // RULE9
      right_gain <= bus.wdata[`GAIN_BITS]; // RULE11
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      left_level <= `RST_LEVEL; // RULE13
      right_level <= `RST_LEVEL; // RULE16
    end
    else if (wr && hit_mix)
    begin
      left_level <= bus.wdata[`LEVEL_HI]; // RULE12
      right_level <= bus.wdata[`LEVEL_LO]; // RULE15
    end
  end

  // Read data captured with the ack pulse
  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
      bus.rdata <= 8'h00;
    else if (take && !bus.we)
    begin
      if (bus.addr == `ADDR_RESERVED_ZERO)
        bus.rdata <= reserved_zero_reg; // RULE17
      else if (bus.addr == `ADDR_HEADSET_DRIVER)
        bus.rdata <= {coupling, full_diff, `RSVD_BIT, headset_sync, pseudo_diff,
          `RSVD_LOW_BITS}; // RULE7
      else if (bus.addr == `ADDR_LEFT_GAIN)
        bus.rdata <= {left_mute, left_gain}; // RULE17
      else if (bus.addr == `ADDR_RIGHT_GAIN)
        bus.rdata <= {right_mute, right_gain}; // RULE17
      else if (bus.addr == `ADDR_SECOND_MIX)
        bus.rdata <= {left_level, right_level}; // RULE17
      else
        bus.rdata <= 8'h00;
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      driver_ac_coupled <= 1'b0;
      full_diff_out <= 1'b0;
      pseudo_diff_out <= 1'b0;
      left_amp_mute <= `RST_MUTE;
      right_amp_mute <= `RST_MUTE;
      left_amp_gain <= `RST_GAIN;
      right_amp_gain <= `RST_GAIN;
      second_left_input_level <= `RST_LEVEL;
      second_left_input_connected <= 1'b0;
      second_right_input_level <= `RST_LEVEL;
      second_right_input_connected <= 1'b0;
    end
    else
    begin
      driver_ac_coupled <= coupling; // RULE2
      full_diff_out <= full_diff; // RULE3
      pseudo_diff_out <= pseudo_diff; // RULE4
      left_amp_mute <= left_mute; // RULE8
      right_amp_mute <= right_mute; // RULE9
      left_amp_gain <= sat_gain(left_gain); // RULE10
      right_amp_gain <= sat_gain(right_gain); // RULE11
      second_left_input_level <= left_level;
      second_left_input_connected <= level_connects(left_level); // RULE14 RULE13
      second_right_input_level <= right_level;
      second_right_input_connected <= level_connects(right_level); // RULE14 RULE16
    end
  end
endmodule
`default_nettype wire

// >>> hdl/codec_regs_host.sv
// Purpose: Host end that issues register reads and writes to the codec bank.
// Assumes: One command at a time; user waits for cmd_ready.
// Notes: Illegal writes are refused with a cmd_error pulse.
`include "codec_regs_defs.svh"
`default_nettype none
module codec_regs_host
  import codec_regs_pkg::*;
(
  input wire logic rst_n,
  codec_regs_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic cmd_error,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  host_state_type state;
  logic legal;
  logic accept;

  function automatic logic level_ok(input level_code_type code);
    level_ok = (code <= `LEVEL_MAX) || (code == `LEVEL_OFF);
  endfunction

  always_comb
  begin
    legal = 1'b1;
    if (cmd_write)
    begin
      if (cmd_addr == `ADDR_RESERVED_ZERO)
        legal = (cmd_wdata == `RST_RESERVED_ZERO); // RULE1
      else if (cmd_addr == `ADDR_HEADSET_DRIVER)
        legal = !(cmd_wdata[`BIT_FULL_DIFF] && cmd_wdata[`BIT_PSEUDO_DIFF]); // RULE5
      else if (cmd_addr == `ADDR_SECOND_MIX)
        legal = level_ok(cmd_wdata[`LEVEL_HI]) && level_ok(cmd_wdata[`LEVEL_LO]); // RULE12 RULE15
    end
  end

  assign cmd_ready = (state == host_idle);
  assign accept = cmd_valid && cmd_ready;

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
      state <= host_idle;
    else
    begin
      case (state)
        host_idle:
          if (accept && legal)
            state <= host_busy;
        host_busy:
          if (bus.ack)
            state <= host_idle;
        default:
          state <= host_idle;
      endcase
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      bus.req <= 1'b0;
      bus.we <= 1'b0;
      bus.addr <= 7'h00;
      bus.wdata <= 8'h00;
    end
    else if (accept && legal)
    begin
      bus.req <= 1'b1;
      bus.we <= cmd_write;
      bus.addr <= cmd_addr;
      if (cmd_addr == `ADDR_HEADSET_DRIVER)
        bus.wdata <= cmd_wdata & `HDC_WRITABLE_MASK; // RULE7
      else
        bus.wdata <= cmd_wdata;
    end
    else if (bus.ack)
      bus.req <= 1'b0;
  end

  always_ff @(posedge bus.clk)
  begin
    if (!rst_n)
    begin
      cmd_error <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end
    else
    begin
      cmd_error <= accept && !legal;
      rsp_valid <= (state == host_busy) && bus.ack;
      if ((state == host_busy) && bus.ack)
        rsp_data <= bus.we ? 8'h00 : bus.rdata;
    end
  end
endmodule
`default_nettype wire

// >>> verif/codec_regs_asserts.sv
// Purpose: Link checks between host and device ends.
// Assumes: One clock, synchronous active-low reset.
// Notes: Request fields stay valid in the ack cycle.
`default_nettype none
module codec_regs_asserts
  import codec_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire reg_addr_type addr,
  input wire reg_data_type wdata,
  input wire logic ack,
  input wire reg_data_type rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic wr;
  logic rd;
  assign wr = req && we;
  assign rd = ack && req && !we;
  function automatic logic bad(input logic [3:0] n);
    return n > 4'h8 && n < 4'hf;
  endfunction
  sequence s_start;
    $rose(req);
  endsequence
  sequence s_pulse;
    ack ##1 !ack;
  endsequence
  a_ack_one_pulse: assert property (s_start |=> s_pulse)
    else $error("ack not a single pulse after req");
  a_req_held: assert property (req && !ack |=> req)
    else $error("req dropped before ack");
  a_rsvd_write: assert property (wr && addr == 7'h0d |-> wdata == 8'h00)
    else $error("nonzero write to reserved register");
  a_rsvd_read: assert property (
    rd && addr == 7'h0d |-> rdata == 8'h00)
    else $error("reserved register read nonzero");
  a_cfg_both_bits: assert property (wr && addr == 7'h0e |-> !(wdata[6] && wdata[3]))
    else $error("both output configurations written");
  a_cfg_rsvd_write: assert property (
    wr && addr == 7'h0e |-> wdata[5] == 1'b0 && wdata[2:0] == 3'h0)
    else $error("reserved config bits written");
  a_cfg_rsvd_read: assert property (
    rd && addr == 7'h0e |-> rdata[5] == 1'b0 && rdata[2:0] == 3'h0)
    else $error("reserved config bits read nonzero");
  a_level_write: assert property (
    wr && addr == 7'h11 |-> !bad(wdata[7:4]) && !bad(wdata[3:0]))
    else $error("forbidden level code written");
endmodule
`default_nettype wire

// >>> verif/test_adc_input_gain_mix_registers.sv
// Purpose: Bench joining host and device ends of the register link.
// Assumes: Commands are issued one at a time.
// Notes: A negedge monitor compares results against queued notes.
`include "codec_regs_defs.svh"
`default_nettype none
module test_adc_input_gain_mix_registers
  import codec_regs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, pin, cv, cw, cmd_ready, cmd_error, rsp_valid;
  reg_addr_type ca;
  reg_data_type cd, rsp_data;
  logic ac, fd, pd, lm, rm, lc, rc;
  logic [6:0] lg, rg;
  logic [3:0] ll, rl;
  logic [8:0] expq[$];
  logic [8:0] e;
  logic [15:0] seed;
  int n_mismatch = 0;
  int samples_checked = 0;
  codec_regs_if codec_regs_if_i (.clk(clk));
  codec_regs_device codec_regs_device_i (.rst_n(rst_n), .bus(codec_regs_if_i), .headset_pin(pin),
    .driver_ac_coupled(ac), .full_diff_out(fd), .pseudo_diff_out(pd), .left_amp_mute(lm),
    .right_amp_mute(rm), .left_amp_gain(lg), .right_amp_gain(rg),
    .second_left_input_level(ll), .second_left_input_connected(lc),
    .second_right_input_level(rl), .second_right_input_connected(rc));
  codec_regs_host codec_regs_host_i (.rst_n(rst_n), .bus(codec_regs_if_i), .cmd_valid(cv),
    .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd), .cmd_ready(cmd_ready),
    .cmd_error(cmd_error), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  codec_regs_asserts codec_regs_asserts_i (.clk(clk), .rst_n(rst_n),
    .req(codec_regs_if_i.req), .we(codec_regs_if_i.we), .addr(codec_regs_if_i.addr),
    .wdata(codec_regs_if_i.wdata), .ack(codec_regs_if_i.ack), .rdata(codec_regs_if_i.rdata));
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmd(input logic w, input reg_addr_type a, input reg_data_type d,
    input logic err, input reg_data_type exp);
    int n;
    expq.push_back({err, exp});
    check("ready", 16'(cmd_ready), 16'h0001);
    cw = w;
    ca = a;
    cd = d;
    cv = 1'b1;
    @(posedge clk);
    #1 cv = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && cmd_error !== 1'b1 && n < 9)
    begin
      @(posedge clk);
      #1 n++;
    end
    check("latency", 16'(n), err ? 16'h0000 : 16'h0002);
    // Let an edge pass so the next command never retouches cmd_valid at once
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input reg_addr_type a, input reg_data_type d);
    cmd(1'b1, a, d, 1'b0, 8'h00);
  endtask
  task automatic rd(input reg_addr_type a, input reg_data_type exp);
    cmd(1'b0, a, 8'h00, 1'b0, exp);
  endtask
  task automatic refuse(input reg_addr_type a, input reg_data_type d);
    cmd(1'b1, a, d, 1'b1, 8'h00);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(negedge clk)
    if (rsp_valid === 1'b1 || cmd_error === 1'b1)
    begin
      e = expq.pop_front();
      check("refused", 16'(cmd_error), 16'(e[8]));
      if (e[8] === 1'b0)
        check("read data", 16'(rsp_data), 16'(e[7:0]));
    end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    reg_data_type tab[6];
    logic [6:0] g;
    logic m;
    logic [3:0] l, r;
    tab = '{8'h00, 8'h00, 8'h80, 8'h80, 8'hff, 8'h00};
    rst_n = 1'b0;
    {pin, cv, cw, ca, cd} = '0;
    seed = 16'h0c98;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    check("reset outs", 16'({ac, fd, pd, lm, rm, lc, rc, ll, rl}), 16'h0cff);
    check("reset gains", 16'({lg, rg}), 16'h0000);
    for (int i = 0; i < 6; i++)
      rd(7'h0d + 7'(i), tab[i]);
    $display("test reset done");
    pin = 1'b1;
    settle();
    rd(7'h0e, 8'h10);
    wr(7'h0e, 8'hc0);
    rd(7'h0e, 8'hd0);
    check("config outs", 16'({ac, fd, pd}), 16'h0006);
    wr(7'h0e, 8'h08);
    pin = 1'b0;
    settle();
    rd(7'h0e, 8'h08);
    check("config outs", 16'({ac, fd, pd}), 16'h0001);
    refuse(7'h0e, 8'h48);
    refuse(7'h0d, 8'h01);
    refuse(7'h11, 8'h9f);
    refuse(7'h11, 8'hfe);
    wr(7'h0d, 8'h00);
    wr(7'h12, 8'h5a);
    rd(7'h12, 8'h00);
    rd(7'h0e, 8'h08);
    $display("test config done");
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      g = i == 0 ? 7'h77 : i == 1 ? 7'h78 : seed[6:0];
      m = seed[7];
      wr(7'h0f, {m, g});
      wr(7'h10, {~m, g});
      rd(7'h0f, {m, g});
      rd(7'h10, {~m, g});
      check("left amp", 16'({lm, lg}), 16'({m, g > 7'h77 ? 7'h77 : g}));
      check("right amp", 16'({rm, rg}), 16'({~m, g > 7'h77 ? 7'h77 : g}));
    end
    $display("test gain done");
    for (int c = 0; c < 16; c++)
      if (c < 9 || c == 15)
      begin
        l = 4'(c);
        r = c == 15 ? 4'h0 : 4'h8 - l;
        wr(7'h11, {l, r});
        rd(7'h11, {l, r});
        check("mix", 16'({ll, lc, rl, rc}), 16'({l, l < 9, r, r < 9}));
      end
    $display("test mix done");
    summarize();
  end
endmodule
`default_nettype wire
